// [counter_array_pkg.sv]
package counter_array_pkg;

  // Register addresses on the special-function-register bus.
  localparam logic [7:0] ADDR_ARRAY_MODE    = 8'hd9;
  localparam logic [7:0] ADDR_CH0_MODE      = 8'hda;
  localparam logic [7:0] ADDR_PWM_CYCLE_CFG = 8'hdf;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'hf9;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hfa;
  localparam logic [7:0] ADDR_CH0_CMP_LOW   = 8'hfb;
  localparam logic [7:0] ADDR_CH0_CMP_HIGH  = 8'hfc;

  // Field positions.
  localparam int BIT_RELOAD_SEL   = 7;
  localparam int BIT_COV_IRQ_EN   = 6;
  localparam int BIT_COV_FLAG     = 5;
  localparam int BIT_WATCHDOG_EN  = 6;
  localparam int BIT_WIDE_PWM     = 7;
  localparam int BIT_PWM_EN       = 1;

  // Reset values.
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic        RST_WATCHDOG_EN = 1'b1;

  localparam logic [1:0] CYCLE_LEN_8BIT = 2'h0;
  localparam logic [3:0] CYCLE_BASE = 4'h8;

endpackage : counter_array_pkg

// [channel_bank_if.sv]
`timescale 1ns/1ps
interface channel_bank_if;
  logic        wr_low;
  logic        wr_high;
  logic        sel_reload;
  logic [7:0]  wdata;
  logic        reload_now;
  logic [15:0] cmp;
  logic [15:0] rld;

  modport ctrl (output wr_low, output wr_high, output sel_reload, output wdata,
                output reload_now, input cmp, input rld);
  modport bank (input wr_low, input wr_high, input sel_reload, input wdata,
                input reload_now, output cmp, output rld);
endinterface : channel_bank_if

// [channel_compare_bank.sv]
`timescale 1ns/1ps
module channel_compare_bank
  import counter_array_pkg::*;
(
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          resetn,
  // Control side
  channel_bank_if.bank      bus
);

  typedef struct packed {
    logic [15:0] cmp;
    logic [15:0] rld;
  } bank_state_t;

  bank_state_t state_r;
  bank_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (bus.reload_now)
    begin
      state_nxt.cmp = state_r.rld;  // R14
    end
    if (bus.sel_reload)  // R1
    begin
      if (bus.wr_low)
      begin
        state_nxt.rld[7:0] = bus.wdata;
      end
      if (bus.wr_high)
      begin
        state_nxt.rld[15:8] = bus.wdata;
      end
    end
    else
    begin
      if (bus.wr_low)
      begin
        state_nxt.cmp[7:0] = bus.wdata;
      end
      if (bus.wr_high)
      begin
        state_nxt.cmp[15:8] = bus.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= '{cmp: RST_WORD, rld: RST_WORD};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign bus.cmp = state_r.cmp;
  assign bus.rld = state_r.rld;

endmodule : channel_compare_bank

// [counter_array_pwm_config.sv]
// Overview of operation
// (R1) Reload-bank select steers compare addresses to compare or auto-reload registers.
// (R2) Auto-reload values act only for channels in 9 to 11-bit PWM.
// (R3) Cycle-overflow flag raises the interrupt only while its enable is set.
// (R4) Cycle-overflow flag sets on overflow at the selected bit 8 to 11.
// (R5) Flag set by hardware or by writing 1; only software clears it.
// (R6) Cycle-length select 00..11 gives 8, 9, 10 or 11-bit cycles.
// (R7) A channel in 16-bit PWM ignores cycle-length select and uses full width.
// (R8) Counter is 16 bits, low and high bytes at own addresses, reset zero.
// (R9) High-byte read returns a snapshot loaded when the low byte is read.
// (R10) Counter writes are ignored while the watchdog is enabled.
// (R11) Channel 0 mode register: eight read-write bits resetting to zero.
// (R12) Watchdog enable bit turns channel 2 into the watchdog; clear disables it.
// (R13) Wide PWM enable selects 16-bit PWM, cleared selects 8 to 11-bit.
// (R14) In 9 to 11-bit PWM, reload copies into compare at each cycle overflow.
`timescale 1ns/1ps
module counter_array_pwm_config
  import counter_array_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Special-function-register bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  // Counter timebase
  input  wire logic        count_tick,
  // Status towards the rest of the counter array
  output logic             irq_request,
  output logic             watchdog_active,
  output logic [15:0]      counter_value,
  output logic [15:0]      ch0_compare,
  output logic [4:0]       ch0_cycle_bits,
  output logic             ch0_wide_pwm
);

  // Every register of the block except the channel 0 compare and reload banks lives in this one record, so the reset
  // branch and the clocked update stay in step when a field is added.
  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  snapshot;
    logic [7:0]  ch0_mode;
    logic        reload_bank_select;
    logic        cycle_overflow_irq_enable;
    logic        cycle_overflow_flag;
    logic [1:0]  cycle_length_select;
    logic        watchdog_enable;
    logic [7:0]  rdata;
  } top_state_t;

  top_state_t state_r;
  top_state_t state_nxt;

  channel_bank_if ch0_if ();

  channel_compare_bank i_channel_compare_bank (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .bus     (ch0_if.bank)
  );

  logic        wr_count_low;
  logic        wr_count_high;
  logic        cycle_wrap;
  logic [10:0] low_mask;
  logic        ch0_pwm_on;
  logic        ch0_short_pwm;

  always_comb
  begin
    // Mask of counter bits that must all be ones for the cycle to wrap.
    // Wide channels never use this mask for their own cycle.
    case (state_r.cycle_length_select)  // R6
      2'h0:    low_mask = 11'h0ff;
      2'h1:    low_mask = 11'h1ff;
      2'h2:    low_mask = 11'h3ff;
      default: low_mask = 11'h7ff;
    endcase
  end

  // The wrap is seen on the tick that carries the selected bit over, which is
  // the instant the counter leaves the last count of a cycle.
  assign cycle_wrap    = count_tick && ((state_r.count[10:0] & low_mask) == low_mask);  // R4
  assign ch0_pwm_on    = state_r.ch0_mode[BIT_PWM_EN];
  assign ch0_wide_pwm  = ch0_pwm_on && state_r.ch0_mode[BIT_WIDE_PWM];  // R13
  // Reload acts only for 9 to 11-bit cycles; 8-bit and 16-bit never reload.
  assign ch0_short_pwm = ch0_pwm_on && !state_r.ch0_mode[BIT_WIDE_PWM]
                         && (state_r.cycle_length_select != CYCLE_LEN_8BIT);  // R2
  // Counter writes are refused while the watchdog is enabled, so a stray
  // store cannot push a running watchdog away from its timeout.
  assign wr_count_low  = sfr_wr && (sfr_addr == ADDR_COUNT_LOW)
                         && !state_r.watchdog_enable;  // R10
  assign wr_count_high = sfr_wr && (sfr_addr == ADDR_COUNT_HIGH)
                         && !state_r.watchdog_enable;  // R10

  // Both banks share the same two byte strobes; the bank module steers
  // them with the select bit.
  assign ch0_if.wr_low     = sfr_wr && (sfr_addr == ADDR_CH0_CMP_LOW);
  assign ch0_if.wr_high    = sfr_wr && (sfr_addr == ADDR_CH0_CMP_HIGH);
  assign ch0_if.sel_reload = state_r.reload_bank_select;  // R1
  assign ch0_if.wdata      = sfr_wdata;
  assign ch0_if.reload_now = cycle_wrap && ch0_short_pwm;  // R14

  always_comb
  begin
    state_nxt = state_r;

    // Byte writes are applied after the increment, so a write wins for its
    // own byte when it meets a tick in the same cycle.
    if (count_tick)
    begin
      state_nxt.count = state_r.count + 16'h0001;
    end
    if (wr_count_low)
    begin
      state_nxt.count[7:0] = sfr_wdata;  // R8
    end
    if (wr_count_high)
    begin
      state_nxt.count[15:8] = sfr_wdata;  // R8
    end

    if (sfr_wr)
    begin
      if (sfr_addr == ADDR_PWM_CYCLE_CFG)
      begin
        // Bits 4:2 are not stored, so they always read back as zero.
        state_nxt.reload_bank_select        = sfr_wdata[BIT_RELOAD_SEL];
        state_nxt.cycle_overflow_irq_enable = sfr_wdata[BIT_COV_IRQ_EN];
        state_nxt.cycle_overflow_flag       = sfr_wdata[BIT_COV_FLAG];  // R5
        state_nxt.cycle_length_select       = sfr_wdata[1:0];
      end
      else if (sfr_addr == ADDR_CH0_MODE)
      begin
        state_nxt.ch0_mode = sfr_wdata;  // R11
      end
      else if (sfr_addr == ADDR_ARRAY_MODE)
      begin
        state_nxt.watchdog_enable = sfr_wdata[BIT_WATCHDOG_EN];  // R12
      end
    end

    // A hardware overflow in the same cycle as a clearing write still sets the flag.
    if (cycle_wrap)
    begin
      state_nxt.cycle_overflow_flag = 1'b1;  // R4
    end

    if (sfr_rd)
    begin
      if (sfr_addr == ADDR_COUNT_LOW)
      begin
        // Freezing the high byte here lets software read a 16-bit value
        // that cannot tear while the counter keeps running.
        state_nxt.rdata    = state_r.count[7:0];
        state_nxt.snapshot = state_r.count[15:8];  // R9
      end
      else if (sfr_addr == ADDR_COUNT_HIGH)
      begin
        state_nxt.rdata = state_r.snapshot;  // R9
      end
      else if (sfr_addr == ADDR_PWM_CYCLE_CFG)
      begin
        state_nxt.rdata = {state_r.reload_bank_select, state_r.cycle_overflow_irq_enable,
                           state_r.cycle_overflow_flag, 3'h0, state_r.cycle_length_select};
      end
      else if (sfr_addr == ADDR_CH0_MODE)
      begin
        state_nxt.rdata = state_r.ch0_mode;
      end
      else if (sfr_addr == ADDR_ARRAY_MODE)
      begin
        state_nxt.rdata = {1'b0, state_r.watchdog_enable, 6'h00};
      end
      else if (sfr_addr == ADDR_CH0_CMP_LOW)
      begin
        state_nxt.rdata = state_r.reload_bank_select ? ch0_if.rld[7:0]
                                                     : ch0_if.cmp[7:0];  // R1
      end
      else if (sfr_addr == ADDR_CH0_CMP_HIGH)
      begin
        state_nxt.rdata = state_r.reload_bank_select ? ch0_if.rld[15:8]
                                                     : ch0_if.cmp[15:8];  // R1
      end
      else
      begin
        state_nxt.rdata = RST_BYTE;
      end
    end
  end

  // The watchdog enable comes out of reset set, so the counter stays
  // locked against writes until software clears that bit.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= '{count: RST_WORD, snapshot: RST_BYTE, ch0_mode: RST_BYTE,
                   reload_bank_select: 1'b0, cycle_overflow_irq_enable: 1'b0,
                   cycle_overflow_flag: 1'b0, cycle_length_select: CYCLE_LEN_8BIT,
                   watchdog_enable: RST_WATCHDOG_EN, rdata: RST_BYTE};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Read data is registered, so it appears the cycle after the strobe
  // and holds until the next read.
  assign sfr_rdata       = state_r.rdata;
  assign irq_request     = state_r.cycle_overflow_flag && state_r.cycle_overflow_irq_enable;  // R3
  assign watchdog_active = state_r.watchdog_enable;  // R12
  assign counter_value   = state_r.count;
  assign ch0_compare     = ch0_if.cmp;
  // A 16-bit channel always runs on the full counter width.
  assign ch0_cycle_bits  = ch0_wide_pwm ? 5'h10
                                        : {3'h0, state_r.cycle_length_select}
                                          + {1'b0, CYCLE_BASE};  // R7

endmodule : counter_array_pwm_config

// [counter_array_pwm_config_properties.sv]
`timescale 1ns/1ps
module counter_array_pwm_config_properties
  import counter_array_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Register bus
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  // Timebase and status
  input wire logic        count_tick,
  input wire logic        irq_request,
  input wire logic        watchdog_active,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] ch0_compare,
  input wire logic [4:0]  ch0_cycle_bits,
  input wire logic        ch0_wide_pwm
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic cfg_wr;
  assign cfg_wr = sfr_wr && sfr_addr == ADDR_PWM_CYCLE_CFG;
  a_irq_masked: assert property (cfg_wr && !sfr_wdata[6] |=> !irq_request)
    else $error("irq while masked");
  a_flag_sticky: assert property (irq_request && !cfg_wr |=> irq_request)
    else $error("flag cleared by itself");
  a_count_step: assert property (
    count_tick && !sfr_wr |=> counter_value == $past(counter_value) + 16'h1)
    else $error("counter missed a step");
  a_count_guard: assert property (
    watchdog_active && !count_tick |=> $stable(counter_value))
    else $error("counter changed while guarded");
  a_low_read: assert property (
    sfr_rd && sfr_addr == ADDR_COUNT_LOW |=> sfr_rdata == $past(counter_value[7:0]))
    else $error("low byte read wrong");
  a_watchdog_bit: assert property (
    sfr_wr && sfr_addr == ADDR_ARRAY_MODE |=> watchdog_active == $past(sfr_wdata[6]))
    else $error("watchdog enable not taken");
  a_wide_length: assert property (ch0_wide_pwm |-> ch0_cycle_bits == 5'h10)
    else $error("wide channel not full width");
  a_short_length: assert property (!ch0_wide_pwm |-> ch0_cycle_bits inside {[5'h8:5'hb]})
    else $error("cycle length out of range");
  a_no_reload: assert property (
    ch0_cycle_bits == 5'h8 && !sfr_wr |=> $stable(ch0_compare))
    else $error("reload in 8-bit cycle");
  c_snapshot: cover property (sfr_rd && sfr_addr == ADDR_COUNT_HIGH);
  c_irq: cover property (irq_request);
  c_wide: cover property (ch0_wide_pwm);
endmodule : counter_array_pwm_config_properties

bind counter_array_pwm_config counter_array_pwm_config_properties i_counter_array_pwm_config_properties (
  .sys_clk, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .count_tick,
  .irq_request, .watchdog_active, .counter_value, .ch0_compare, .ch0_cycle_bits, .ch0_wide_pwm);

// [counter_array_pwm_config_bench.sv]
`timescale 1ns/1ps
module counter_array_pwm_config_bench
  import counter_array_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic        count_tick = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        irq_request;
  logic        watchdog_active;
  logic [15:0] counter_value;
  logic [15:0] ch0_compare;
  logic [4:0]  ch0_cycle_bits;
  logic        ch0_wide_pwm;
  int          n_errors = 0;
  int          total_checks = 0;
  counter_array_pwm_config i_counter_array_pwm_config (
    .sys_clk, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .count_tick,
    .irq_request, .watchdog_active, .counter_value, .ch0_compare, .ch0_cycle_bits, .ch0_wide_pwm);
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    chk(16'(sfr_rdata), 16'(e));
  endtask : rd
  task automatic tick(input int n);
    @(posedge sys_clk);
    count_tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    count_tick <= 1'b0;
    #1;
  endtask : tick
  task automatic t_reset;
    rd(ADDR_ARRAY_MODE, 8'h40);
    rd(ADDR_CH0_MODE, 8'h00);
    rd(ADDR_PWM_CYCLE_CFG, 8'h00);
    rd(ADDR_COUNT_LOW, 8'h00);
    rd(ADDR_COUNT_HIGH, 8'h00);
  endtask : t_reset
  // Counter writes are dropped while the watchdog runs, so it is cleared after a first dropped write.
  task automatic t_counter;
    wr(ADDR_COUNT_LOW, 8'h34);
    rd(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_ARRAY_MODE, 8'h00);
    chk(16'(watchdog_active), 16'h0000);
    wr(ADDR_COUNT_LOW, 8'h34);
    wr(ADDR_COUNT_HIGH, 8'h12);
    rd(ADDR_COUNT_LOW, 8'h34);
    wr(ADDR_COUNT_HIGH, 8'h56);
    rd(ADDR_COUNT_HIGH, 8'h12);
    chk(counter_value, 16'h5634);
    wr(ADDR_ARRAY_MODE, 8'h40);
    rd(ADDR_ARRAY_MODE, 8'h40);
    wr(ADDR_COUNT_HIGH, 8'h99);
    chk(counter_value, 16'h5634);
    wr(ADDR_ARRAY_MODE, 8'h00);
  endtask : t_counter
  task automatic t_mode;
    wr(ADDR_CH0_MODE, 8'ha5);
    rd(ADDR_CH0_MODE, 8'ha5);
    wr(ADDR_CH0_MODE, 8'h82);
    wr(ADDR_PWM_CYCLE_CFG, 8'h03);
    chk(16'({ch0_wide_pwm, ch0_cycle_bits}), 16'h0030);
    wr(ADDR_CH0_MODE, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_PWM_CYCLE_CFG, 8'(i));
      chk(16'(ch0_cycle_bits), 16'(8 + i));
    end
  endtask : t_mode
  // The 9-bit boundary is reached from 0x01fe so that two ticks cross it.
  task automatic t_reload;
    wr(ADDR_PWM_CYCLE_CFG, 8'h81);
    wr(ADDR_CH0_CMP_LOW, 8'h22);
    wr(ADDR_CH0_CMP_HIGH, 8'h01);
    rd(ADDR_CH0_CMP_LOW, 8'h22);
    wr(ADDR_PWM_CYCLE_CFG, 8'h01);
    rd(ADDR_CH0_CMP_LOW, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'h01);
    tick(2);
    chk(16'(irq_request), 16'h0000);
    rd(ADDR_PWM_CYCLE_CFG, 8'h21);
    chk(ch0_compare, 16'h0122);
    wr(ADDR_PWM_CYCLE_CFG, 8'h61);
    chk(16'(irq_request), 16'h0001);
    wr(ADDR_PWM_CYCLE_CFG, 8'h41);
    chk(16'(irq_request), 16'h0000);
    wr(ADDR_PWM_CYCLE_CFG, 8'h61);
    chk(16'(irq_request), 16'h0001);
    wr(ADDR_PWM_CYCLE_CFG, 8'h80);
    wr(ADDR_CH0_CMP_LOW, 8'h77);
    wr(ADDR_PWM_CYCLE_CFG, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hff);
    tick(1);
    chk(ch0_compare, 16'h0122);
    rd(ADDR_PWM_CYCLE_CFG, 8'h20);
    wr(ADDR_CH0_CMP_HIGH, 8'h45);
    chk(ch0_compare, 16'h4522);
    rd(ADDR_CH0_CMP_HIGH, 8'h45);
    wr(ADDR_CH0_MODE, 8'h82);
    wr(ADDR_PWM_CYCLE_CFG, 8'h01);
    wr(ADDR_COUNT_LOW, 8'hff);
    tick(1);
    chk(ch0_compare, 16'h4522);
    rd(ADDR_PWM_CYCLE_CFG, 8'h21);
  endtask : t_reload
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_counter();
    t_mode();
    t_reload();
    give_verdict();
  end
endmodule : counter_array_pwm_config_bench
